// >>> rtl/vih_map.vh
// Register offsets, field positions and reset values of the vectored interrupt handler.
`ifndef VIH_MAP_VH
`define VIH_MAP_VH

// ************************************************************
// Word offsets on the register bus
// ************************************************************
`define VIH_OFS_BASIC_EN      4'h0
`define VIH_OFS_BASIC_PRIO    4'h1
`define VIH_OFS_EXT_EN1       4'h2
`define VIH_OFS_EXT_EN2       4'h3
`define VIH_OFS_EXT_PRIO1     4'h4
`define VIH_OFS_EXT_PRIO2     4'h5
`define VIH_OFS_TIMER_CTRL    4'h6
`define VIH_OFS_TIMER2_CTRL   4'h7
`define VIH_OFS_PORT3_FLAG    4'h8
`define VIH_OFS_PEND0         4'h9
`define VIH_OFS_PEND1         4'hA
`define VIH_OFS_PEND2         4'hB
`define VIH_OFS_STATUS        4'hC

// ************************************************************
// Field positions
// ************************************************************
`define VIH_BIT_GLOBAL_EN     7
`define VIH_BIT_EXT0_TRIG     0
`define VIH_BIT_EXT0_PEND     1
`define VIH_BIT_EXT1_TRIG     2
`define VIH_BIT_EXT1_PEND     3
`define VIH_BIT_TMR0_OVF      5
`define VIH_BIT_TMR1_OVF      7
`define VIH_BIT_TMR2_OVF      7
`define VIH_BIT_TMR2_EXT      6
`define VIH_BIT_EXT6_POL      2
`define VIH_BIT_EXT7_POL      3
`define VIH_BIT_EXT6_PEND     5
`define VIH_BIT_EXT7_PEND     6
`define VIH_BIT_XTAL_VALID    7

// ************************************************************
// Source order numbers
// ************************************************************
`define VIH_SRC_COUNT         22
`define VIH_SRC_EXT0          0
`define VIH_SRC_TMR0          1
`define VIH_SRC_EXT1          2
`define VIH_SRC_TMR1          3
`define VIH_SRC_TMR2          5
`define VIH_SRC_EXT6          18
`define VIH_SRC_EXT7          19
`define VIH_SRC_XTAL          21

// ************************************************************
// Vectors and reset values
// ************************************************************
`define VIH_RESET_VECTOR      16'h0000
`define VIH_VEC_LOW_BITS      3'b011
`define VIH_RST_BYTE          8'h00
`define VIH_PRIO_UNUSED_RD    2'b11
`define VIH_SYNC_RST          5'b0_0011

`endif

// >>> rtl/vih_prio_enc.v
// Fixed-order priority encoder: lowest set index wins.
`timescale 1ns/10ps
`default_nettype none

module vih_prio_enc (
    // Request vector
    input  wire [21:0] req,
    // Result
    output reg         found,
    output reg  [4:0]  index
);

    integer i;

    always @* begin
        found = 1'b0;
        index = 5'h00;
        for (i = 21; i >= 0; i = i - 1) begin
            if (req[i]) begin
                found = 1'b1;
                index = i[4:0];
            end
        end
    end

endmodule // vih_prio_enc

`default_nettype wire

// >>> rtl/vih_handler.v
// Vectored interrupt handler with Avalon-MM register slave.
// Operation
// - Twenty-two sources, each one of two levels.
// - Valid condition sets pending flag regardless of enable.
// - Enabled pending flag requests call after instruction.
// - Return resumes the interrupted instruction stream.
// - Disabled pending flag produces no request.
// - Global enable gates every individual enable.
// - Flag still set after return re-requests after one instruction.
// - Software setting a flag acts as real event.
// - External 0/1 active low, level or edge.
// - Edge external 0/1 flag clears on vectoring.
// - Level external 0/1 flag follows the pin.
// - External 6/7 edge, selectable polarity, port3 flags.
// - Reset vector zero; source n at 3 plus 8n.
// - Timer 0/1 flags clear on vectoring, others kept.
// - Enable bits split over basic and extended registers.
// - Priority bits mirror the enable mapping.
// - Timer 2 overflow or external flag share vector.
// - Crystal valid flag is source 21 pending.
// - High preempts low; high wins, then lower index.
// - Requests sampled and decoded every clock cycle.
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "vih_map.vh"

module vih_handler (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Avalon-MM slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Peripheral events, one-cycle pulses from the system clock domain
    input  wire [21:0] src_event,
    input  wire        timer2_ext_event,
    // External pins and oscillator status
    input  wire        ext_irq0_n,
    input  wire        ext_irq1_n,
    input  wire        ext_irq6,
    input  wire        ext_irq7,
    input  wire        xtal_valid,
    // CPU core
    input  wire        cpu_irq_ack,
    input  wire        cpu_return_from_irq,
    input  wire        cpu_instr_done,
    output reg         irq_req,
    output reg  [15:0] irq_vector,
    output reg  [4:0]  irq_source
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    reg  [4:0]  sync1_r;
    reg  [4:0]  sync2_r;
    reg  [4:0]  prev_r;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= `VIH_SYNC_RST;
            sync2_r <= `VIH_SYNC_RST;
            prev_r  <= `VIH_SYNC_RST;
        end else begin
            sync1_r <= {xtal_valid, ext_irq7, ext_irq6, ext_irq1_n, ext_irq0_n};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    reg  [7:0]  basic_irq_enable_reg;
    reg  [5:0]  basic_priority_reg;
    reg  [7:0]  extended_enable_reg1;
    reg  [7:0]  extended_enable_reg2;
    reg  [7:0]  extended_priority_reg1;
    reg  [7:0]  extended_priority_reg2;
    reg         ext0_trigger_select;
    reg         ext1_trigger_select;
    reg         ext6_pol_r;
    reg         ext7_pol_r;
    reg  [20:0] pend_r;
    reg         timer2_external_flag;

    wire        global_irq_enable = basic_irq_enable_reg[`VIH_BIT_GLOBAL_EN];
    wire        crystal_valid_flag = sync2_r[4];

    // ************************************************************
    // Bus slave: one wait state, write lands when waitrequest is low
    // ************************************************************
    reg         ack_r;
    wire        acc = avs_read | avs_write;
    wire        wr_go = avs_write & ack_r;
    wire [7:0]  wd = avs_writedata[7:0];

    assign avs_waitrequest = acc & ~ack_r;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= acc & ~ack_r;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            basic_irq_enable_reg   <= `VIH_RST_BYTE;
            basic_priority_reg     <= 6'h00;
            extended_enable_reg1   <= `VIH_RST_BYTE;
            extended_enable_reg2   <= `VIH_RST_BYTE;
            extended_priority_reg1 <= `VIH_RST_BYTE;
            extended_priority_reg2 <= `VIH_RST_BYTE;
            ext0_trigger_select    <= 1'b0;
            ext1_trigger_select    <= 1'b0;
            ext6_pol_r             <= 1'b0;
            ext7_pol_r             <= 1'b0;
        end else if (wr_go) begin
            case (avs_address)
                `VIH_OFS_BASIC_EN:    basic_irq_enable_reg   <= wd;
                `VIH_OFS_BASIC_PRIO:  basic_priority_reg     <= wd[5:0];
                `VIH_OFS_EXT_EN1:     extended_enable_reg1   <= wd;
                `VIH_OFS_EXT_EN2:     extended_enable_reg2   <= wd;
                `VIH_OFS_EXT_PRIO1:   extended_priority_reg1 <= wd;
                `VIH_OFS_EXT_PRIO2:   extended_priority_reg2 <= wd;
                `VIH_OFS_TIMER_CTRL: begin
                    ext0_trigger_select <= wd[`VIH_BIT_EXT0_TRIG];
                    ext1_trigger_select <= wd[`VIH_BIT_EXT1_TRIG];
                end
                `VIH_OFS_PORT3_FLAG: begin
                    ext6_pol_r <= wd[`VIH_BIT_EXT6_POL];
                    ext7_pol_r <= wd[`VIH_BIT_EXT7_POL];
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Software view of the pending flags
    // ************************************************************
    reg  [20:0] sw_wen;
    reg  [20:0] sw_val;

    always @* begin
        sw_wen = 21'h00_0000;
        sw_val = 21'h00_0000;
        if (wr_go) begin
            case (avs_address)
                `VIH_OFS_TIMER_CTRL: begin
                    sw_wen[`VIH_SRC_EXT0] = 1'b1;
                    sw_val[`VIH_SRC_EXT0] = wd[`VIH_BIT_EXT0_PEND];
                    sw_wen[`VIH_SRC_TMR0] = 1'b1;
                    sw_val[`VIH_SRC_TMR0] = wd[`VIH_BIT_TMR0_OVF];
                    sw_wen[`VIH_SRC_EXT1] = 1'b1;
                    sw_val[`VIH_SRC_EXT1] = wd[`VIH_BIT_EXT1_PEND];
                    sw_wen[`VIH_SRC_TMR1] = 1'b1;
                    sw_val[`VIH_SRC_TMR1] = wd[`VIH_BIT_TMR1_OVF];
                end
                `VIH_OFS_TIMER2_CTRL: begin
                    sw_wen[`VIH_SRC_TMR2] = 1'b1;
                    sw_val[`VIH_SRC_TMR2] = wd[`VIH_BIT_TMR2_OVF];
                end
                `VIH_OFS_PORT3_FLAG: begin
                    sw_wen[`VIH_SRC_EXT6] = 1'b1;
                    sw_val[`VIH_SRC_EXT6] = wd[`VIH_BIT_EXT6_PEND];
                    sw_wen[`VIH_SRC_EXT7] = 1'b1;
                    sw_val[`VIH_SRC_EXT7] = wd[`VIH_BIT_EXT7_PEND];
                end
                `VIH_OFS_PEND0: begin
                    sw_wen[5:0] = 6'h3F;
                    sw_val[5:0] = wd[5:0];
                end
                `VIH_OFS_PEND1: begin
                    sw_wen[13:6] = 8'hFF;
                    sw_val[13:6] = wd;
                end
                `VIH_OFS_PEND2: begin
                    sw_wen[20:14] = 7'h7F;
                    sw_val[20:14] = wd[6:0];
                end
                default: begin
                end
            endcase
        end
    end

    wire        t2_ext_wen = wr_go && (avs_address == `VIH_OFS_TIMER2_CTRL);

    // ************************************************************
    // Hardware set and clear of the pending flags
    // ************************************************************
    wire        act6 = ext6_pol_r ? sync2_r[2] : ~sync2_r[2];
    wire        act6_prev = ext6_pol_r ? prev_r[2] : ~prev_r[2];
    wire        act7 = ext7_pol_r ? sync2_r[3] : ~sync2_r[3];
    wire        act7_prev = ext7_pol_r ? prev_r[3] : ~prev_r[3];

    reg  [20:0] hw_set;
    reg  [20:0] hw_clr;
    reg  [4:0]  ack_idx;

    always @* begin
        hw_set = src_event[20:0];
        hw_set[`VIH_SRC_EXT0] = src_event[`VIH_SRC_EXT0] | (~sync2_r[0] & prev_r[0]);
        hw_set[`VIH_SRC_EXT1] = src_event[`VIH_SRC_EXT1] | (~sync2_r[1] & prev_r[1]);
        hw_set[`VIH_SRC_EXT6] = src_event[`VIH_SRC_EXT6] | (act6 & ~act6_prev);
        hw_set[`VIH_SRC_EXT7] = src_event[`VIH_SRC_EXT7] | (act7 & ~act7_prev);
        hw_clr = 21'h00_0000;
        if (cpu_irq_ack) begin
            case (ack_idx)
                `VIH_SRC_EXT0: hw_clr[`VIH_SRC_EXT0] = 1'b1;
                `VIH_SRC_EXT1: hw_clr[`VIH_SRC_EXT1] = 1'b1;
                `VIH_SRC_TMR0: hw_clr[`VIH_SRC_TMR0] = 1'b1;
                `VIH_SRC_TMR1: hw_clr[`VIH_SRC_TMR1] = 1'b1;
                default: begin
                end
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < 21; g = g + 1) begin : g_pend
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    pend_r[g] <= 1'b0;
                end else if (g == `VIH_SRC_EXT0 && !ext0_trigger_select) begin
                    pend_r[g] <= ~sync2_r[0];
                end else if (g == `VIH_SRC_EXT1 && !ext1_trigger_select) begin
                    pend_r[g] <= ~sync2_r[1];
                end else if (hw_set[g]) begin
                    pend_r[g] <= 1'b1;
                end else if (sw_wen[g]) begin
                    pend_r[g] <= sw_val[g];
                end else if (hw_clr[g]) begin
                    pend_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timer2_external_flag <= 1'b0;
        end else if (timer2_ext_event) begin
            timer2_external_flag <= 1'b1;
        end else if (t2_ext_wen) begin
            timer2_external_flag <= wd[`VIH_BIT_TMR2_EXT];
        end
    end

    // ************************************************************
    // Gating and priority decode
    // ************************************************************
    wire [21:0] pend_eff;
    wire [21:0] en_vec;
    wire [21:0] prio_vec;

    assign pend_eff = {crystal_valid_flag, pend_r[20:6],
                       pend_r[5] | timer2_external_flag, pend_r[4:0]};
    assign en_vec   = {extended_enable_reg2, extended_enable_reg1,
                       basic_irq_enable_reg[5:0]};
    assign prio_vec = {extended_priority_reg2, extended_priority_reg1,
                       basic_priority_reg};

    reg         svc_hi_r;
    reg         svc_lo_r;
    reg         hold_r;
    wire [21:0] elig = pend_eff & en_vec & {22{global_irq_enable}};
    wire [21:0] hi_req = elig & prio_vec;
    wire [21:0] lo_req = elig & ~prio_vec;
    wire        hi_found;
    wire [4:0]  hi_idx;
    wire        lo_found;
    wire [4:0]  lo_idx;

    vih_prio_enc u_hi_enc (
        .req   (hi_req),
        .found (hi_found),
        .index (hi_idx)
    );

    vih_prio_enc u_lo_enc (
        .req   (lo_req),
        .found (lo_found),
        .index (lo_idx)
    );

    wire        hi_ok = hi_found & ~svc_hi_r & ~hold_r;
    wire        lo_ok = lo_found & ~svc_hi_r & ~svc_lo_r & ~hold_r;
    wire [4:0]  win_idx = hi_ok ? hi_idx : lo_idx;

    always @* begin
        ack_idx = irq_source;
    end

    // Request and vector are re-decided on every clock edge.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_req    <= 1'b0;
            irq_source <= 5'h00;
            irq_vector <= `VIH_RESET_VECTOR;
        end else begin
            irq_req    <= (hi_ok | lo_ok) & ~cpu_irq_ack;
            irq_source <= win_idx;
            irq_vector <= {8'h00, win_idx, `VIH_VEC_LOW_BITS};
        end
    end

    // ************************************************************
    // Service level tracking
    // ************************************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            svc_hi_r <= 1'b0;
            svc_lo_r <= 1'b0;
            hold_r   <= 1'b0;
        end else begin
            if (cpu_irq_ack) begin
                if (prio_vec[irq_source]) begin
                    svc_hi_r <= 1'b1;
                end else begin
                    svc_lo_r <= 1'b1;
                end
            end else if (cpu_return_from_irq) begin
                if (svc_hi_r) begin
                    svc_hi_r <= 1'b0;
                end else begin
                    svc_lo_r <= 1'b0;
                end
            end
            if (cpu_return_from_irq) begin
                hold_r <= 1'b1;
            end else if (cpu_instr_done) begin
                hold_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    reg  [7:0]  rd_byte;

    always @* begin
        rd_byte = 8'h00;
        case (avs_address)
            `VIH_OFS_BASIC_EN:    rd_byte = basic_irq_enable_reg;
            `VIH_OFS_BASIC_PRIO:  rd_byte = {`VIH_PRIO_UNUSED_RD, basic_priority_reg};
            `VIH_OFS_EXT_EN1:     rd_byte = extended_enable_reg1;
            `VIH_OFS_EXT_EN2:     rd_byte = extended_enable_reg2;
            `VIH_OFS_EXT_PRIO1:   rd_byte = extended_priority_reg1;
            `VIH_OFS_EXT_PRIO2:   rd_byte = extended_priority_reg2;
            `VIH_OFS_TIMER_CTRL: begin
                rd_byte[`VIH_BIT_EXT0_TRIG] = ext0_trigger_select;
                rd_byte[`VIH_BIT_EXT0_PEND] = pend_r[`VIH_SRC_EXT0];
                rd_byte[`VIH_BIT_EXT1_TRIG] = ext1_trigger_select;
                rd_byte[`VIH_BIT_EXT1_PEND] = pend_r[`VIH_SRC_EXT1];
                rd_byte[`VIH_BIT_TMR0_OVF]  = pend_r[`VIH_SRC_TMR0];
                rd_byte[`VIH_BIT_TMR1_OVF]  = pend_r[`VIH_SRC_TMR1];
            end
            `VIH_OFS_TIMER2_CTRL: begin
                rd_byte[`VIH_BIT_TMR2_OVF] = pend_r[`VIH_SRC_TMR2];
                rd_byte[`VIH_BIT_TMR2_EXT] = timer2_external_flag;
            end
            `VIH_OFS_PORT3_FLAG: begin
                rd_byte[`VIH_BIT_EXT6_POL]  = ext6_pol_r;
                rd_byte[`VIH_BIT_EXT7_POL]  = ext7_pol_r;
                rd_byte[`VIH_BIT_EXT6_PEND] = pend_r[`VIH_SRC_EXT6];
                rd_byte[`VIH_BIT_EXT7_PEND] = pend_r[`VIH_SRC_EXT7];
            end
            `VIH_OFS_PEND0:       rd_byte = {2'b00, pend_eff[5:0]};
            `VIH_OFS_PEND1:       rd_byte = pend_eff[13:6];
            `VIH_OFS_PEND2:       rd_byte = pend_eff[21:14];
            `VIH_OFS_STATUS:      rd_byte = {irq_req, 4'h0, hold_r, svc_hi_r, svc_lo_r};
            default:              rd_byte = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack_r) begin
            avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

endmodule // vih_handler

`default_nettype wire

// >>> dv/vih_monitor.sv
// Concurrent checks on the ports of the vectored interrupt handler.
`timescale 1ns/10ps
`default_nettype none

module vih_monitor (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Register bus
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // CPU side
    input wire logic        cpu_irq_ack,
    input wire logic        cpu_return_from_irq,
    input wire logic        cpu_instr_done,
    input wire logic        irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic [4:0]  irq_source
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // Number of service routines the CPU has entered and not yet left.
    logic [1:0] depth_r;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            depth_r <= 2'd0;
        end else if (cpu_irq_ack && !cpu_return_from_irq) begin
            depth_r <= depth_r + 2'd1;
        end else if (cpu_return_from_irq && !cpu_irq_ack) begin
            depth_r <= depth_r - 2'd1;
        end
    end

    sequence bus_start;
        !(avs_read || avs_write) ##1 (avs_read || avs_write);
    endsequence

    sequence ret_quiet;
        cpu_return_from_irq && !cpu_instr_done ##1 !cpu_instr_done;
    endsequence

    bus_wait_a: assert property (bus_start |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("register access did not take one wait state");
    ack_drop_a: assert property (cpu_irq_ack |=> !irq_req)
        else $error("request stayed up after acknowledge");
    vec_form_a: assert property (irq_req |-> irq_vector == {8'h00, irq_source, 3'b011})
        else $error("vector does not match source");
    src_range_a: assert property (irq_req |-> irq_source < 5'd22)
        else $error("source index out of range");
    return_from_irq_gap_a: assert property (ret_quiet |=> !irq_req)
        else $error("request before the instruction after return");
    rst_idle_a: assert property ($rose(rstn) |-> !irq_req && irq_vector == 16'h0000)
        else $error("outputs not idle after reset");
    nest_max_a: assert property (depth_r <= 2'd2)
        else $error("more than two nested service routines");
    full_block_a: assert property (depth_r == 2'd2 |-> !irq_req)
        else $error("request while high level in service");
endmodule // vih_monitor

bind vih_handler vih_monitor mon (
    .clk, .rstn, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .cpu_irq_ack, .cpu_return_from_irq, .cpu_instr_done, .irq_req, .irq_vector, .irq_source
);

`default_nettype wire

// >>> dv/vih_cpu_model.sv
// Behavioural CPU core that takes interrupt calls and returns from them.
`timescale 1ns/10ps
`default_nettype none

module vih_cpu_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Handler side
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    output logic             cpu_irq_ack,
    output logic             cpu_return_from_irq,
    output logic             cpu_instr_done,
    // Bench control
    input  wire logic        ret_go,
    output logic [15:0]      last_vec,
    output int               ack_cnt
);
    logic [1:0] step_r;

    // An instruction completes every third cycle; a return restarts the count.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            step_r <= 2'd0;
            cpu_irq_ack <= 1'b0;
            cpu_return_from_irq <= 1'b0;
            cpu_instr_done <= 1'b0;
            last_vec <= 16'h0000;
            ack_cnt <= 0;
        end else begin
            step_r <= (ret_go || step_r == 2'd2) ? 2'd0 : step_r + 2'd1;
            cpu_instr_done <= step_r == 2'd2 && !ret_go;
            cpu_return_from_irq <= ret_go;
            cpu_irq_ack <= irq_req && cpu_instr_done && !cpu_irq_ack;
            if (irq_req && cpu_instr_done && !cpu_irq_ack) begin
                last_vec <= irq_vector;
                ack_cnt <= ack_cnt + 1;
            end
        end
    end
endmodule // vih_cpu_model

`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the vectored interrupt handler.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [21:0] src_event = 22'h00_0000;
    logic        timer2_ext_event = 1'b0;
    logic        ext_irq0_n = 1'b1;
    logic        ext_irq6 = 1'b0;
    logic        xtal_valid = 1'b0;
    logic        cpu_irq_ack;
    logic        cpu_return_from_irq;
    logic        cpu_instr_done;
    logic        irq_req;
    logic [15:0] irq_vector;
    logic [4:0]  irq_source;
    logic        ret_go = 1'b0;
    logic [15:0] last_vec;
    int          ack_cnt;
    int          errors = 0;
    int          total_checks = 0;

    always #20 clk = ~clk;

    vih_handler dut (
        .clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .src_event, .timer2_ext_event,
        .ext_irq0_n, .ext_irq1_n(ext_irq0_n), .ext_irq6, .ext_irq7(ext_irq6), .xtal_valid,
        .cpu_irq_ack, .cpu_return_from_irq, .cpu_instr_done, .irq_req, .irq_vector, .irq_source
    );

    vih_cpu_model cpu (
        .clk, .rstn, .irq_req, .irq_vector, .cpu_irq_ack, .cpu_return_from_irq,
        .cpu_instr_done, .ret_go, .last_vec, .ack_cnt
    );

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic stall;
        errors++;
        $display("wrong value wait expected answer seen timeout");
        final_report;
    endtask

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
        total_checks++;
        if (got !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h00_0000, d};
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 20) stall();
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk("register", {8'h00, e}, {8'h00, q});
    endtask

    task automatic wait_vec(input logic [15:0] e);
        int c;
        int n;
        c = ack_cnt;
        for (n = 0; n < 60 && ack_cnt == c; n++) @(posedge clk);
        if (ack_cnt == c) stall();
        chk("vector", e, last_vec);
    endtask

    task automatic ret;
        @(posedge clk);
        ret_go <= 1'b1;
        @(posedge clk);
        ret_go <= 1'b0;
    endtask

    task automatic pulse(input int s);
        @(posedge clk);
        src_event <= 22'h00_0001 << s;
        @(posedge clk);
        src_event <= 22'h00_0000;
    endtask

    task automatic t_regs;
        rd(4'h1, 8'hc0);
        rd(4'hc, 8'h00);
        wr(4'hd, 8'hff);
        rd(4'hd, 8'h00);
        wr(4'h3, 8'h40);
        rd(4'h3, 8'h40);
        wr(4'h3, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_mask;
        wr(4'h2, 8'h02);
        pulse(7);
        rd(4'ha, 8'h02);
        @(negedge clk);
        chk("request", 16'h0000, {15'h0000, irq_req});
        wr(4'h0, 8'h80);
        wait_vec(16'h003b);
        rd(4'ha, 8'h02);
        ret;
        wait_vec(16'h003b);
        wr(4'ha, 8'h00);
        ret;
        pulse(8);
        repeat (4) @(negedge clk);
        chk("request", 16'h0000, {15'h0000, irq_req});
        rd(4'ha, 8'h04);
        wr(4'ha, 8'h00);
        $display("test mask done");
    endtask

    task automatic t_prio;
        wr(4'h2, 8'h09);
        wr(4'h4, 8'h08);
        wr(4'ha, 8'h09);
        wait_vec(16'h004b);
        wr(4'ha, 8'h01);
        ret;
        wait_vec(16'h0033);
        wr(4'ha, 8'h09);
        wait_vec(16'h004b);
        wr(4'ha, 8'h00);
        ret;
        ret;
        wr(4'h2, 8'h00);
        wr(4'h4, 8'h00);
        $display("test priority done");
    endtask

    task automatic t_tmr;
        wr(4'h0, 8'ha2);
        pulse(1);
        @(negedge clk);
        chk("request", 16'h0000, {15'h0000, irq_req});
        @(negedge clk);
        chk("request", 16'h0001, {15'h0000, irq_req});
        wait_vec(16'h000b);
        rd(4'h6, 8'h00);
        ret;
        @(posedge clk);
        timer2_ext_event <= 1'b1;
        @(posedge clk);
        timer2_ext_event <= 1'b0;
        wait_vec(16'h002b);
        rd(4'h7, 8'h40);
        wr(4'h7, 8'h00);
        ret;
        $display("test timers done");
    endtask

    task automatic t_ext;
        wr(4'h6, 8'h01);
        wr(4'h0, 8'h81);
        @(posedge clk);
        ext_irq0_n <= 1'b0;
        repeat (3) @(posedge clk);
        ext_irq0_n <= 1'b1;
        wait_vec(16'h0003);
        rd(4'h6, 8'h01);
        ret;
        wr(4'h0, 8'h80);
        wr(4'h6, 8'h00);
        ext_irq0_n <= 1'b0;
        repeat (5) @(posedge clk);
        rd(4'h6, 8'h0a);
        ext_irq0_n <= 1'b1;
        repeat (5) @(posedge clk);
        rd(4'h6, 8'h00);
        wr(4'h8, 8'h04);
        ext_irq6 <= 1'b1;
        repeat (5) @(posedge clk);
        rd(4'h8, 8'h24);
        wr(4'h3, 8'h40);
        wr(4'hb, 8'h40);
        wait_vec(16'h00a3);
        wr(4'hb, 8'h00);
        ret;
        xtal_valid <= 1'b1;
        repeat (5) @(posedge clk);
        rd(4'hb, 8'h80);
        $display("test external done");
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_mask;
        t_prio;
        t_tmr;
        t_ext;
        final_report;
    end
endmodule // testbench

`default_nettype wire
